// ===== src/ulm_pkg.sv
// Shared constants for the line and modem status register block
package ulm_pkg;
    // Register byte addresses
    localparam logic [4:0] OFS_MODEM_CONTROL = 5'h00;
    localparam logic [4:0] OFS_LINE_STATUS = 5'h04;
    localparam logic [4:0] OFS_MODEM_STATUS = 5'h08;
    localparam logic [4:0] OFS_SCRATCH = 5'h0C;
    localparam logic [4:0] OFS_FEATURE_CONTROL = 5'h10;
    localparam logic [4:0] OFS_ENHANCED_FEATURE = 5'h14;
    localparam logic [4:0] OFS_INTERRUPT_ENABLE = 5'h18;

    // Modem control fields
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_RING = 2;
    localparam int MCR_CARRIER = 3;
    localparam int MCR_LOOP = 4;
    localparam int MCR_IR = 6;
    localparam int MCR_PRESCALE = 7;

    // Other control fields
    localparam int FEATURE_CONTROL_REG_SWAP = 6;
    localparam int FEATURE_CONTROL_REG_HYST_LO = 0;
    localparam int ENHANCED_MODE_SEL_REG_MODE_LO = 0;
    localparam int ENHANCED_MODE_SEL_REG_HYST_LO = 4;
    localparam int EFR_AUTO_CTS = 7;
    localparam int IER_MODEM = 3;

    // Reset values
    localparam logic [7:0] RST_MODEM_CONTROL = 8'h00;
    localparam logic [7:0] RST_SCRATCH = 8'hFF;
    localparam logic [7:0] RST_FEATURE_CONTROL = 8'h00;
    localparam logic [7:0] RST_ENHANCED_FEATURE = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_ENABLE = 8'h00;
    localparam logic [7:0] RST_ENHANCED_MODE = 8'h00;

    // Level count modes of the swapped scratch address
    localparam logic [1:0] CNT_MODE_RX = 2'h0;
    localparam logic [1:0] CNT_MODE_TX = 2'h1;
    localparam logic [1:0] CNT_MODE_RX2 = 2'h2;
    localparam logic [1:0] CNT_MODE_ALT = 2'h3;

    // Baud prescaler ratio when divide-by-four is chosen
    localparam int PRESCALE_DIV = 4;

    // Hysteresis in characters, entry 15 first, index {ext[1:0], low[1:0]}
    localparam logic [95:0] HYST_TABLE = {
        6'h24, 6'h1C, 6'h14, 6'h0C, 6'h34, 6'h30, 6'h2C, 6'h28,
        6'h20, 6'h18, 6'h10, 6'h08, 6'h08, 6'h06, 6'h04, 6'h00};

    // Which count the next alternating read returns
    typedef enum logic {ULM_ALT_RX, ULM_ALT_TX} ulm_alt_t;
endpackage

// ===== src/ulm_status_regs.sv
// Line status, modem status and mode registers of one serial channel
// Summary of operation
// [RL1] Infrared bit routes serial through IR codec; IR transmit idles low.
// [RL2] Prescale bit feeds baud generator undivided or divided by four.
// [RL3] Receive ready is set while any received character is held.
// [RL4] Character completing into a full FIFO flags overrun and is dropped.
// [RL5] Parity error reports only the character at the receive head.
// [RL6] Framing error reports a missing stop bit on the head character.
// [RL7] Break stores one character only; indication holds until line high.
// [RL8] Holding-empty follows holding byte moves, or empty transmit FIFO.
// [RL9] Transmitter empty only when holding storage and shifter are both empty.
// [RL10] FIFO error summary set while any queued byte carries an error.
// [RL11] CTS, DSR, CD changes set deltas and raise modem interrupt if enabled.
// [RL12] Ring delta sets only on ring input going from 0 to 1.
// [RL13] Outside loopback upper status bits are complements of modem inputs.
// [RL14] In loopback status bits mirror RTS, DTR, control bits 2 and 3.
// [RL15] Auto CTS: remote high stops transmit after current character, low resumes.
// [RL16] Scratch is 8-bit read/write and resets to all ones.
// [RL17] With swap set, scratch writes go to enhanced mode select.
// [RL18] Mode field picks receive, transmit, receive or alternating counts.
// [RL19] Alternating mode starts at receive count after mode write, then alternates.
// [RL20] Four bits select RTS hysteresis from the sixteen-entry table.
// [RL21] With swap set, scratch reads return the FIFO level count.
// [RL22] Loopback bit in modem control enables status mirroring.
// [RL23] Status reads clear deltas, overrun and head error reporting.
`timescale 1ns/10ps
module ulm_status_regs #(
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rx_pin,
    input wire logic cts_n_pin,
    input wire logic dsr_n_pin,
    input wire logic ri_n_pin,
    input wire logic cd_n_pin,
    output logic dtr_n_pin,
    output logic rts_n_pin,
    output logic tx_pin,
    input wire logic tx_serial,
    input wire logic ir_tx_pulse,
    input wire logic ir_rx_decoded,
    output logic rx_data,
    output logic ir_mode,
    output logic baud_tick,
    input wire logic fifo_mode,
    input wire logic rx_char_done,
    input wire logic rx_char_par,
    input wire logic rx_char_frm,
    input wire logic rx_break_frame,
    input wire logic rx_fifo_full,
    input wire logic rx_pop,
    input wire logic [CNT_W-1:0] rx_count,
    input wire logic head_par,
    input wire logic head_frm,
    input wire logic head_brk,
    input wire logic [CNT_W-1:0] tx_count,
    input wire logic thr_load,
    input wire logic tsr_load,
    input wire logic tsr_busy,
    output logic rx_store,
    output logic rx_store_par,
    output logic rx_store_frm,
    output logic rx_store_brk,
    output logic tx_hold,
    output logic [5:0] rts_hyst,
    output logic modem_irq
);
    // Software registers
    // Scratch resets to ones
    logic [7:0] modem_control;
    logic [7:0] scratch_store;
    logic [7:0] enhanced_mode_select;
    logic [7:0] feature_control;
    logic [7:0] enhanced_feature;
    logic [7:0] interrupt_enable;

    // Status state
    // Error count one bit wider
    logic overrun;
    logic err_ack;
    logic brk_active;
    logic thr_empty;
    logic [3:0] delta;
    logic [3:0] prev_level;
    logic primed;
    logic [CNT_W:0] err_count;
    logic [1:0] pre_cnt;
    ulm_pkg::ulm_alt_t alt_phase;
    ulm_pkg::ulm_alt_t next_alt;

    // Bus read pipeline
    // Held wait to take
    logic rd_done;
    logic [4:0] cap_addr;
    logic [7:0] cap_data;

    // Pin synchronisers, stage one feeds stage two only
    // Reset to idle high
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_s1 <= 5'h1F;
            pin_s2 <= 5'h1F;
        end else begin
            pin_s1 <= {rx_pin, cd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin};
            pin_s2 <= pin_s1;
        end
    end

    // Synchronised pin levels
    // Pins are active low
    wire cts_n = pin_s2[0];
    wire dsr_n = pin_s2[1];
    wire ri_n = pin_s2[2];
    wire cd_n = pin_s2[3];
    wire rx_line = pin_s2[4];
    wire loop_on = modem_control[ulm_pkg::MCR_LOOP];

    // Modem status levels: inverted pins, or control bits in loopback
    // Loopback ignores pins
    wire [3:0] pin_level = {~cd_n, ~ri_n, ~dsr_n, ~cts_n}; // RL13
    wire [3:0] loop_level = {modem_control[ulm_pkg::MCR_CARRIER],
        modem_control[ulm_pkg::MCR_RING],
        modem_control[ulm_pkg::MCR_DTR],
        modem_control[ulm_pkg::MCR_RTS]}; // RL14
    wire [3:0] level = loop_on ? loop_level : pin_level; // RL22

    // Change events; ring only when its input rises, status bit falls
    // No delta at first edge
    wire [3:0] chg = prev_level ^ level;
    wire [3:0] delta_set = primed ? {chg[3], prev_level[2] & ~level[2], chg[1:0]}
        : 4'h0; // RL11 RL12

    // Bus decode
    // Byte lane zero only
    wire wr_lane = avs_write && avs_byteenable[0];
    wire [7:0] wbyte = avs_writedata[7:0];
    wire swap = feature_control[ulm_pkg::FEATURE_CONTROL_REG_SWAP];
    wire wr_mcr = wr_lane && avs_address == ulm_pkg::OFS_MODEM_CONTROL;
    wire wr_scr_addr = wr_lane && avs_address == ulm_pkg::OFS_SCRATCH;
    wire wr_scratch = wr_scr_addr && !swap; // RL16
    wire wr_enhanced_mode_sel_reg = wr_scr_addr && swap; // RL17
    wire wr_feature_control_reg = wr_lane && avs_address == ulm_pkg::OFS_FEATURE_CONTROL;
    wire wr_efr = wr_lane && avs_address == ulm_pkg::OFS_ENHANCED_FEATURE;
    wire wr_ier = wr_lane && avs_address == ulm_pkg::OFS_INTERRUPT_ENABLE;
    wire rd_take = avs_read && rd_done;
    wire take_lsr = rd_take && cap_addr == ulm_pkg::OFS_LINE_STATUS;
    wire take_msr = rd_take && cap_addr == ulm_pkg::OFS_MODEM_STATUS;
    wire take_lvl = rd_take && cap_addr == ulm_pkg::OFS_SCRATCH && swap;

    // Writes complete at once, reads after one wait cycle
    // Data from a flip-flop
    assign avs_waitrequest = avs_read && !rd_done;

    // Receive storage: one break character per low period, none into a full FIFO
    // Full FIFO kept intact
    wire brk_new = rx_break_frame && !brk_active; // RL7
    wire rx_arrive = rx_char_done || brk_new;
    assign rx_store = rx_arrive && !rx_fifo_full; // RL4
    assign rx_store_par = rx_char_par && !brk_new;
    assign rx_store_frm = rx_char_frm && !brk_new;
    assign rx_store_brk = brk_new;
    wire ovr_set = rx_arrive && rx_fifo_full; // RL4
    wire push_err = rx_store && (rx_store_par || rx_store_frm || rx_store_brk);

    // Line status fields
    // Read hides head flags
    wire data_ready = rx_count != '0; // RL3
    wire head_ok = data_ready && !err_ack;
    wire lsr_par = head_ok && head_par; // RL5
    wire lsr_frm = head_ok && head_frm; // RL6
    wire lsr_brk = (head_ok && head_brk) || brk_active; // RL7
    wire thre = fifo_mode ? tx_count == '0 : thr_empty; // RL8
    wire temt = thre && !tsr_busy; // RL9
    wire fifo_err = err_count != '0; // RL10
    wire [7:0] lsr_val = {fifo_err, temt, thre, lsr_brk, lsr_frm, lsr_par,
        overrun, data_ready};
    wire [7:0] msr_val = {level, delta};

    // Level count seen through the swapped scratch address
    // Count cut to a byte
    wire [1:0] cnt_mode = enhanced_mode_select[ulm_pkg::ENHANCED_MODE_SEL_REG_MODE_LO +: 2];
    wire alt_tx = cnt_mode == ulm_pkg::CNT_MODE_ALT && alt_phase == ulm_pkg::ULM_ALT_TX;
    wire use_tx = cnt_mode == ulm_pkg::CNT_MODE_TX || alt_tx; // RL18 RL19
    wire [CNT_W-1:0] lvl_cnt = use_tx ? tx_count : rx_count;
    wire [7:0] lvl_val = 8'(lvl_cnt);
    wire [7:0] scr_val = swap ? lvl_val : scratch_store; // RL21

    // Read mux over the mapped addresses, zero elsewhere
    // Unmapped reads zero
    logic [7:0] rd_mux;
    always_comb begin
        case (avs_address)
            ulm_pkg::OFS_MODEM_CONTROL: rd_mux = modem_control;
            ulm_pkg::OFS_LINE_STATUS: rd_mux = lsr_val;
            ulm_pkg::OFS_MODEM_STATUS: rd_mux = msr_val;
            ulm_pkg::OFS_SCRATCH: rd_mux = scr_val;
            ulm_pkg::OFS_FEATURE_CONTROL: rd_mux = feature_control;
            ulm_pkg::OFS_ENHANCED_FEATURE: rd_mux = enhanced_feature;
            ulm_pkg::OFS_INTERRUPT_ENABLE: rd_mux = interrupt_enable;
            default: rd_mux = 8'h00;
        endcase
    end

    // Read capture: data fixed at the wait edge, side effects at the taking edge
    // Later changes kept
    // One effect per read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_done <= 1'b0;
            cap_addr <= 5'h00;
            cap_data <= 8'h00;
        end else begin
            rd_done <= avs_read && !rd_done;
            if (avs_read && !rd_done) begin
                cap_addr <= avs_address;
                cap_data <= rd_mux;
            end
        end
    end
    assign avs_readdata = {24'h00_0000, cap_data};

    // Control registers
    // Status takes no write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            modem_control <= ulm_pkg::RST_MODEM_CONTROL;
            scratch_store <= ulm_pkg::RST_SCRATCH; // RL16
            enhanced_mode_select <= ulm_pkg::RST_ENHANCED_MODE;
            feature_control <= ulm_pkg::RST_FEATURE_CONTROL;
            enhanced_feature <= ulm_pkg::RST_ENHANCED_FEATURE;
            interrupt_enable <= ulm_pkg::RST_INTERRUPT_ENABLE;
        end else begin
            if (wr_mcr)
                modem_control <= wbyte;
            if (wr_scratch)
                scratch_store <= wbyte;
            if (wr_enhanced_mode_sel_reg)
                enhanced_mode_select <= wbyte; // RL17
            if (wr_feature_control_reg)
                feature_control <= wbyte;
            if (wr_efr)
                enhanced_feature <= wbyte;
            if (wr_ier)
                interrupt_enable <= wbyte;
        end
    end

    // Alternating count phase: a mode write restarts at receive
    // Alternating reads step
    always_comb begin
        next_alt = alt_phase;
        case (alt_phase)
            ulm_pkg::ULM_ALT_RX: if (take_lvl && cnt_mode == ulm_pkg::CNT_MODE_ALT)
                next_alt = ulm_pkg::ULM_ALT_TX;
            ulm_pkg::ULM_ALT_TX: if (take_lvl)
                next_alt = ulm_pkg::ULM_ALT_RX;
            default: next_alt = ulm_pkg::ULM_ALT_RX;
        endcase
        if (wr_enhanced_mode_sel_reg)
            next_alt = ulm_pkg::ULM_ALT_RX; // RL19
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            alt_phase <= ulm_pkg::ULM_ALT_RX;
        else
            alt_phase <= next_alt;
    end

    // Modem deltas: a new change wins over the read that clears
    // Clear only deltas seen
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            delta <= 4'h0;
            prev_level <= 4'h0;
            primed <= 1'b0;
        end else begin
            primed <= 1'b1;
            prev_level <= level;
            delta <= (delta & ~(take_msr ? cap_data[3:0] : 4'h0)) | delta_set; // RL23 RL11
        end
    end
    assign modem_irq = interrupt_enable[ulm_pkg::IER_MODEM] && delta != 4'h0; // RL11

    // Overrun flag and head error acknowledge
    // Ack only a real head,
    // so new heads show errors
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            overrun <= 1'b0;
            err_ack <= 1'b0;
        end else begin
            overrun <= (overrun && !(take_lsr && cap_data[1])) || ovr_set; // RL4 RL23
            if (rx_pop)
                err_ack <= 1'b0;
            else if (take_lsr && cap_data[0])
                err_ack <= 1'b1; // RL23
        end
    end

    // Break low period tracking; ends when the line is back high
    // New break beats line high
    always_ff @(posedge clk) begin
        if (sys_rst)
            brk_active <= 1'b0;
        else if (brk_new)
            brk_active <= 1'b1;
        else if (rx_line)
            brk_active <= 1'b0; // RL7
    end

    // Count of queued bytes that carry an error
    // Push and pop cancel
    wire pop_err = rx_pop && data_ready && (head_par || head_frm || head_brk);
    always_ff @(posedge clk) begin
        if (sys_rst)
            err_count <= '0;
        else if (push_err && !pop_err)
            err_count <= err_count + 1'b1; // RL10
        else if (pop_err && !push_err && err_count != '0)
            err_count <= err_count - 1'b1; // RL10
    end

    // Holding empty in character mode: host load clears, move to shifter sets
    // Shifter move beats load
    always_ff @(posedge clk) begin
        if (sys_rst)
            thr_empty <= 1'b1;
        else if (tsr_load)
            thr_empty <= 1'b1; // RL8
        else if (thr_load)
            thr_empty <= 1'b0; // RL8
    end

    // Baud prescaler: every cycle, or one in four
    // First tick may come early
    always_ff @(posedge clk) begin
        if (sys_rst)
            pre_cnt <= 2'h0;
        else
            pre_cnt <= pre_cnt + 2'h1;
    end
    wire [1:0] pre_last = 2'(ulm_pkg::PRESCALE_DIV - 1);
    assign baud_tick = !modem_control[ulm_pkg::MCR_PRESCALE] || pre_cnt == pre_last; // RL2

    // Serial routing through the infrared codec
    // IR output idles low
    assign ir_mode = modem_control[ulm_pkg::MCR_IR];
    assign tx_pin = ir_mode ? (ir_tx_pulse && tsr_busy) : tx_serial; // RL1
    assign rx_data = ir_mode ? ir_rx_decoded : rx_line; // RL1

    // Modem outputs, held inactive while looped back
    // Far side sees no loop test
    assign dtr_n_pin = loop_on || !modem_control[ulm_pkg::MCR_DTR];
    assign rts_n_pin = loop_on || !modem_control[ulm_pkg::MCR_RTS];

    // Auto CTS: transmitter checks this before starting each character
    // Checked per character
    assign tx_hold = enhanced_feature[ulm_pkg::EFR_AUTO_CTS] && !level[0]; // RL15

    // Hysteresis lookup
    // Extended pair on top
    wire [3:0] hyst_idx = {enhanced_mode_select[ulm_pkg::ENHANCED_MODE_SEL_REG_HYST_LO +: 2],
        feature_control[ulm_pkg::FEATURE_CONTROL_REG_HYST_LO +: 2]};
    assign rts_hyst = ulm_pkg::HYST_TABLE[hyst_idx*6 +: 6]; // RL20
endmodule

// ===== verif/test_uart_line_modem_status_regs.sv
// Self-checking bench for the line and modem status registers
`timescale 1ns/10ps
module test_uart_line_modem_status_regs;
    localparam int CNT_W = 8;
    localparam int HYST[16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};
    logic clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, fifo_mode = 1, slow = 0;
    logic [4:0] avs_address = '0, want = 5'h1F;
    logic [31:0] avs_writedata = '0, avs_readdata;
    logic [3:0] avs_byteenable = 4'hF, o, p;
    logic avs_waitrequest, rx_pin, cts_n_pin, dsr_n_pin, ri_n_pin, cd_n_pin, dtr_n_pin;
    logic rts_n_pin, tx_pin, rx_data, ir_mode, baud_tick, rx_store, rx_store_par;
    logic rx_store_frm, rx_store_brk, tx_hold, modem_irq;
    logic [5:0] rts_hyst;
    logic tx_serial = 0, ir_tx_pulse = 0, ir_rx_decoded = 0, rx_char_done = 0;
    logic rx_char_par = 0, rx_char_frm = 0, rx_break_frame = 0, rx_fifo_full = 0;
    logic rx_pop = 0, head_par = 0, head_frm = 0, head_brk = 0, thr_load = 0;
    logic tsr_load = 0, tsr_busy = 0;
    logic [CNT_W-1:0] rx_count = '0, tx_count = '0;
    logic [7:0] d, v, s;
    int n_errors = 0, check_count = 0;

    ulm_status_regs #(.CNT_W(CNT_W)) i_dut (.*);
    ulm_modem_peer i_peer (.clk, .want, .slow, .rx_pin, .cd_n_pin, .ri_n_pin, .dsr_n_pin,
        .cts_n_pin);

    always #2.5 clk = ~clk;
    // Shifter and codec lines wander freely
    always @(posedge clk) {tx_serial, ir_tx_pulse, ir_rx_decoded} <= 3'($urandom);

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [4:0] a, logic [7:0] dat);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, dat};
        avs_write <= 1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 0;
    endtask
    task automatic rdc(string what, logic [4:0] a, logic [7:0] exp, logic [7:0] m = 8'hFF);
        @(posedge clk);
        avs_address <= a;
        avs_read <= 1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 0;
        chk(what, exp & m, avs_readdata[7:0] & m);
    endtask
    // Status image of modem pins pv after old pins q: levels inverted, deltas
    function automatic logic [7:0] msr_exp(logic [3:0] pv, logic [3:0] q);
        return {~pv, ((pv ^ q) & 4'hB) | (~q & pv & 4'h4)};
    endfunction

    // Cut a hung run short
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report;
    end

    initial begin
        void'($urandom(89));
        repeat (12) @(posedge clk);
        sys_rst <= 0;
        // Scratch store, unmapped read
        rdc("scratch reset", ulm_pkg::OFS_SCRATCH, 8'hFF);
        s = 8'($urandom);
        wr(ulm_pkg::OFS_SCRATCH, s);
        rdc("scratch", ulm_pkg::OFS_SCRATCH, s);
        rdc("unmapped", 5'h1C, 8'h00);
        // Random modem pin changes, deltas, interrupt and clear on read
        wr(ulm_pkg::OFS_MODEM_CONTROL, 8'h01);
        wr(ulm_pkg::OFS_INTERRUPT_ENABLE, 8'h08);
        o = 4'hF;
        for (int i = 0; i < 12; i++) begin
            p = 4'($urandom);
            want <= {1'b1, p};
            slow <= 1'($urandom);
            repeat (9) @(posedge clk);
            d = msr_exp(p, o);
            chk("modem irq", 32'(|d[3:0]), 32'(modem_irq));
            rdc("modem status", ulm_pkg::OFS_MODEM_STATUS, d);
            @(posedge clk);
            chk("irq after read", 0, 32'(modem_irq));
            o = p;
        end
        // Loopback mirrors control bits and parks the modem outputs
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom) & 8'h0F;
            wr(ulm_pkg::OFS_MODEM_CONTROL, 8'h10 | v);
            @(posedge clk);
            chk("parked outputs", 2'b11, {dtr_n_pin, rts_n_pin});
            rdc("loop status", ulm_pkg::OFS_MODEM_STATUS, {v[3:2], v[0], v[1], 4'h0}, 8'hF0);
        end
        wr(ulm_pkg::OFS_MODEM_CONTROL, 8'h00);
        // Automatic clear-to-send pause and resume
        wr(ulm_pkg::OFS_ENHANCED_FEATURE, 8'h80);
        want <= 5'h1F;
        repeat (8) @(posedge clk);
        chk("tx hold", 1, 32'(tx_hold));
        want <= 5'h1E;
        repeat (8) @(posedge clk);
        chk("tx resume", 0, 32'(tx_hold));
        // Every hysteresis entry and every level count mode
        for (int i = 0; i < 16; i++) begin
            rx_count <= CNT_W'($urandom);
            tx_count <= CNT_W'($urandom);
            wr(ulm_pkg::OFS_FEATURE_CONTROL, 8'h40 | 8'(i & 3));
            wr(ulm_pkg::OFS_SCRATCH, 8'((i >> 2) << 4) | 8'(i & 3));
            @(posedge clk);
            chk("hysteresis", HYST[i], 32'(rts_hyst));
            for (int k = 0; k < 3; k++) begin
                d = ((i & 3) == 1 || ((i & 3) == 3 && k == 1)) ? tx_count : rx_count;
                rdc("level", ulm_pkg::OFS_SCRATCH, d);
            end
        end
        wr(ulm_pkg::OFS_FEATURE_CONTROL, 8'h00);
        rdc("scratch kept", ulm_pkg::OFS_SCRATCH, s);
        // Empty receiver with busy shifter
        rx_count <= '0;
        tx_count <= '0;
        tsr_busy <= 1;
        rdc("idle status", ulm_pkg::OFS_LINE_STATUS, 8'h20, 8'h61);
        // Erroneous store, then overrun, then head flags
        tsr_busy <= 0;
        rx_count <= CNT_W'(5);
        {head_par, head_frm} <= 2'($urandom);
        rx_char_done <= 1;
        rx_char_par <= 1;
        rx_char_frm <= 1'($urandom);
        @(posedge clk);
        rx_fifo_full <= 1;
        @(posedge clk);
        rx_char_done <= 0;
        rx_fifo_full <= 0;
        rdc("errors", ulm_pkg::OFS_LINE_STATUS, {4'hE, head_frm, head_par, 2'b11});
        rdc("errors read", ulm_pkg::OFS_LINE_STATUS, 8'hE1);
        head_par <= 1;
        head_frm <= 0;
        rx_pop <= 1;
        @(posedge clk);
        rx_pop <= 0;
        rdc("after pop", ulm_pkg::OFS_LINE_STATUS, 8'h04, 8'h84);
        // Character mode holding flag
        fifo_mode <= 0;
        thr_load <= 1;
        @(posedge clk);
        thr_load <= 0;
        rdc("holding full", ulm_pkg::OFS_LINE_STATUS, 8'h00, 8'h60);
        tsr_load <= 1;
        @(posedge clk);
        tsr_load <= 0;
        rdc("holding empty", ulm_pkg::OFS_LINE_STATUS, 8'h60, 8'h60);
        fifo_mode <= 1;
        // Break on a low line is stored once and held while low
        want <= 5'h0E;
        repeat (8) @(posedge clk);
        chk("rx line", 0, 32'(rx_data));
        @(posedge clk);
        rx_break_frame <= 1;
        for (int k = 0; k < 2; k++) begin
            @(negedge clk);
            chk("break store", 32'(k == 0), 32'(rx_store));
            @(posedge clk);
        end
        rx_break_frame <= 0;
        rdc("break", ulm_pkg::OFS_LINE_STATUS, 8'h10, 8'h10);
        want <= 5'h1E;
        // Prescaler and infrared mode
        wr(ulm_pkg::OFS_MODEM_CONTROL, 8'hC0);
        @(posedge clk);
        d = 0;
        repeat (8) begin
            @(negedge clk);
            d += 8'(baud_tick);
        end
        chk("tick count", 2, d);
        chk("ir mode", 1, 32'(ir_mode));
        chk("ir rx", 32'(ir_rx_decoded), 32'(rx_data));
        chk("ir idle", 0, 32'(tx_pin));
        // Reset in mid-run restores the scratch store
        @(posedge clk);
        sys_rst <= 1;
        repeat (2) @(posedge clk);
        sys_rst <= 0;
        rdc("scratch reset again", ulm_pkg::OFS_SCRATCH, 8'hFF);
        final_report;
    end
endmodule

// ===== verif/ulm_modem_peer.sv
// Remote modem and line model driving the serial side inputs
`timescale 1ns/10ps
module ulm_modem_peer (
    input wire logic clk,
    input wire logic [4:0] want,
    input wire logic slow,
    output logic rx_pin,
    output logic cd_n_pin,
    output logic ri_n_pin,
    output logic dsr_n_pin,
    output logic cts_n_pin
);
    logic [4:0] lag1 = 5'h1F;
    logic [4:0] lag2 = 5'h1F;
    logic [4:0] lag3 = 5'h1F;
    // A prompt peer shows new levels after one edge, a slow one after three
    always_ff @(posedge clk) begin
        lag1 <= want;
        lag2 <= lag1;
        lag3 <= lag2;
    end
    // High on cts_n pauses the local transmitter, low resumes it
    assign {rx_pin, cd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin} = slow ? lag3 : lag1;
endmodule

// ===== verif/ulm_status_props.sv
// Concurrent checks on the ports of the status register block
`timescale 1ns/10ps
module ulm_status_props #(
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic rx_pin,
    input wire logic cts_n_pin,
    input wire logic dsr_n_pin,
    input wire logic ri_n_pin,
    input wire logic cd_n_pin,
    input wire logic dtr_n_pin,
    input wire logic tx_pin,
    input wire logic tx_serial,
    input wire logic ir_tx_pulse,
    input wire logic ir_mode,
    input wire logic baud_tick,
    input wire logic rx_char_done,
    input wire logic rx_char_par,
    input wire logic rx_char_frm,
    input wire logic rx_break_frame,
    input wire logic rx_fifo_full,
    input wire logic [CNT_W-1:0] rx_count,
    input wire logic tsr_busy,
    input wire logic rx_store,
    input wire logic rx_store_par,
    input wire logic rx_store_frm,
    input wire logic rx_store_brk
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // First cycle of a read, where the value is captured
    wire logic rd_cap;
    wire logic [3:0] pin_vec;
    assign rd_cap = avs_read && avs_waitrequest;
    assign pin_vec = {cd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin};

    a_ir_route: assert property (
        tx_pin == (ir_mode ? (ir_tx_pulse && tsr_busy) : tx_serial))
        else $error("serial output routing wrong");
    a_prescale_gap: assert property (
        $fell(baud_tick) && !$past(baud_tick, 2) |-> !baud_tick [*3] ##1 baud_tick)
        else $error("divided baud tick not one in four");
    a_overrun_drop: assert property (
        rx_char_done && rx_fifo_full |-> !rx_store)
        else $error("character stored into full fifo");
    a_store_flags: assert property (
        rx_char_done && !rx_fifo_full && !rx_break_frame |-> rx_store
        && rx_store_par == rx_char_par && rx_store_frm == rx_char_frm && !rx_store_brk)
        else $error("stored character flags wrong");
    a_break_once: assert property (
        rx_store && rx_store_brk && !rx_pin && !$past(rx_pin) && !$past(rx_pin, 2)
        |=> !(rx_store && rx_store_brk))
        else $error("second break character stored");
    a_ready_bit: assert property (
        rd_cap && avs_address == ulm_pkg::OFS_LINE_STATUS
        |=> avs_readdata[0] == ($past(rx_count) != '0))
        else $error("receive ready bit wrong");
    a_temt_busy: assert property (
        rd_cap && avs_address == ulm_pkg::OFS_LINE_STATUS && tsr_busy |=> !avs_readdata[6])
        else $error("transmitter empty while shifting");
    a_modem_level: assert property (
        rd_cap && avs_address == ulm_pkg::OFS_MODEM_STATUS && !dtr_n_pin
        && pin_vec == $past(pin_vec) && pin_vec == $past(pin_vec, 2)
        && pin_vec == $past(pin_vec, 3) |=> avs_readdata[7:4] == ~$past(pin_vec))
        else $error("modem input levels wrong");
endmodule

bind ulm_status_regs ulm_status_props #(.CNT_W(CNT_W)) i_props (.*);
